/* File: design/cmo_engine.sv */
`timescale 1ns/1ps

module cmo_engine
	import cmo_pkg::*;
(
	// clock, reset, enable
	input  wire logic        i_ref_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_ce,
	// instruction issue
	input  wire logic        i_req_valid,
	input  wire cmo_req_s    i_req,
	output logic             o_req_ready,
	// base register read
	output logic [4:0]       o_base_sel,
	input  wire logic [31:0] i_base_data,
	// completion
	output logic             o_done,
	output logic             o_hit,
	// coprocessor registers
	input  wire logic        i_tag_low_we,
	input  wire logic [31:0] i_tag_low_wdata,
	output logic [31:0]      o_tag_low,
	input  wire logic        i_way_select_test_enable,
	// line write back
	output logic             o_wb_req,
	output logic [31:0]      o_wb_addr,
	input  wire logic        i_wb_ack,
	// line refill
	output logic             o_fill_req,
	output logic [31:0]      o_fill_addr,
	input  wire logic        i_fill_ack
);

	typedef enum logic [2:0] {
		ST_IDLE, ST_EVAL, ST_WB, ST_FILL, ST_WRITE
	} cmo_state_e;

	cmo_state_e             state_r;
	logic [31:0]            ea_r;
	logic [4:0]             op_r;
	logic                   tag_we_r;
	logic                   lru_we_r;
	cmo_set_t               set_wr_r;
	logic [CMO_LRU_W-1:0]   lru_wr_r;
	logic [31:0]            ea_nxt;
	logic [CMO_IDX_W-1:0]   ram_addr;
	cmo_set_t               set_rd;
	logic [CMO_LRU_W-1:0]   lru_rd;
	logic                   accept;
	logic [CMO_WAYS-1:0]    hit_vec;
	logic                   hit_any;
	logic [CMO_WAY_W-1:0]   hit_way;
	logic [CMO_WAY_W-1:0]   victim;
	logic                   free_any;
	logic [CMO_WAY_W-1:0]   free_way;
	logic [CMO_WAY_W-1:0]   tgt;
	logic                   do_wb;
	logic                   do_fill;
	logic                   do_tag_we;
	logic                   do_lru_we;
	logic                   do_load;
	cmo_set_t               set_nxt;
	logic [CMO_LRU_W-1:0]   lru_nxt;
	logic [2:0]             cmd;
	logic                   is_dcache;
	logic                   sel_ok;
	logic [CMO_TAG_W-1:0]   ea_tag;
	logic [CMO_SET_W-1:0]   ea_set;

	// oldest way of an lru code
	function automatic logic [CMO_WAY_W-1:0] lru_oldest(input logic [CMO_LRU_W-1:0] c);
		if (!c[CMO_LRU_P01] && !c[CMO_LRU_P02] && !c[CMO_LRU_P03]) begin
			return 2'h0;
		end else if (c[CMO_LRU_P01] && !c[CMO_LRU_P12] && !c[CMO_LRU_P13]) begin
			return 2'h1;
		end else if (c[CMO_LRU_P02] && c[CMO_LRU_P12] && !c[CMO_LRU_P23]) begin
			return 2'h2;
		end else begin
			return 2'h3;
		end
	endfunction

	// make one way the most recent, keeping the others in order
	function automatic logic [CMO_LRU_W-1:0] lru_touch(input logic [CMO_LRU_W-1:0] c,
		input logic [CMO_WAY_W-1:0] w);
		logic [CMO_LRU_W-1:0] n;
		n = c;
		unique case (w)
			2'h0: begin
				n[CMO_LRU_P01] = 1'b1;
				n[CMO_LRU_P02] = 1'b1;
				n[CMO_LRU_P03] = 1'b1;
			end
			2'h1: begin
				n[CMO_LRU_P01] = 1'b0;
				n[CMO_LRU_P12] = 1'b1;
				n[CMO_LRU_P13] = 1'b1;
			end
			2'h2: begin
				n[CMO_LRU_P02] = 1'b0;
				n[CMO_LRU_P12] = 1'b0;
				n[CMO_LRU_P23] = 1'b1;
			end
			2'h3: begin
				n[CMO_LRU_P03] = 1'b0;
				n[CMO_LRU_P13] = 1'b0;
				n[CMO_LRU_P23] = 1'b0;
			end
		endcase
		return n;
	endfunction

	assign o_req_ready = (state_r == ST_IDLE);
	assign accept      = i_ce && i_req_valid && o_req_ready;
	assign o_base_sel  = i_req.base_sel;

	assign ea_nxt = i_base_data + {{16{i_req.offset[15]}}, i_req.offset};

	// index fields of the latched address
	assign ea_tag = ea_r[31:CMO_EA_TAG_LSB];
	assign ea_set = ea_r[CMO_EA_WAY_LSB-1:CMO_EA_SET_LSB];
	assign cmd    = op_r[4:CMO_OP_CMD_LSB];

	// cache select, reserved selects do nothing
	assign is_dcache = (op_r[1:CMO_OP_SEL_LSB] == CMO_SEL_DCACHE);
	assign sel_ok    = (op_r[1:CMO_OP_SEL_LSB] == CMO_SEL_ICACHE) || is_dcache;

	// array read fires on accept so data is ready in the evaluate cycle
	always_comb begin
		if (state_r == ST_IDLE) begin
			ram_addr = {i_req.op[0], ea_nxt[CMO_EA_WAY_LSB-1:CMO_EA_SET_LSB]};
		end else begin
			ram_addr = {op_r[0], ea_set};
		end
	end

	generate
		for (genvar w = 0; w < CMO_WAYS; w++) begin : g_cmp
			assign hit_vec[w] = set_rd[w].valid && (set_rd[w].tag == ea_tag);
		end
	endgenerate

	// hit way and first free way; a multiple hit takes the lowest
	always_comb begin
		hit_any  = 1'b0;
		hit_way  = '0;
		free_any = 1'b0;
		free_way = '0;
		for (int w = CMO_WAYS - 1; w >= 0; w--) begin
			if (hit_vec[w]) begin
				hit_any = 1'b1;
				hit_way = CMO_WAY_W'(w);
			end
			if (!set_rd[w].valid) begin
				free_any = 1'b1;
				free_way = CMO_WAY_W'(w);
			end
		end
	end

	// refill victim, free way before the oldest
	assign victim = free_any ? free_way : lru_oldest(lru_rd);

	// operation decode in the evaluate cycle
	always_comb begin
		tgt       = ea_r[CMO_EA_WAY_LSB +: CMO_WAY_W];
		do_wb     = 1'b0;
		do_fill   = 1'b0;
		do_tag_we = 1'b0;
		do_lru_we = 1'b0;
		do_load   = 1'b0;
		set_nxt   = set_rd;
		lru_nxt   = lru_rd;
		if (sel_ok) begin
			unique case (cmd)
				CMO_CMD_IDX_INV: begin
					set_nxt[tgt].valid = 1'b0;
					set_nxt[tgt].dirty = 1'b0;
					do_tag_we          = 1'b1;
					// dirty data block goes out first
					do_wb = is_dcache && set_rd[tgt].valid && set_rd[tgt].dirty;
				end
				CMO_CMD_LOAD_TAG: begin
					do_load = 1'b1;
				end
				CMO_CMD_STORE_TAG: begin
					// test mode writes the way-select array
					if (i_way_select_test_enable) begin
						lru_nxt   = o_tag_low[CMO_TL_LRU_LSB +: CMO_LRU_W];
						do_lru_we = 1'b1;
					end else begin
						set_nxt[tgt].tag   = o_tag_low[31:CMO_TL_TAG_LSB];
						set_nxt[tgt].valid = o_tag_low[CMO_TL_VALID_BIT];
						set_nxt[tgt].dirty = o_tag_low[CMO_TL_DIRTY_BIT];
						do_tag_we          = 1'b1;
					end
				end
				CMO_CMD_HIT_INV: begin
					// drop on hit, dirty data discarded
					tgt                = hit_way;
					set_nxt[tgt].valid = 1'b0;
					set_nxt[tgt].dirty = 1'b0;
					do_tag_we          = hit_any;
				end
				CMO_CMD_FILL: begin
					if (is_dcache) begin
						// write back if dirty, then invalidate
						tgt                = hit_way;
						set_nxt[tgt].valid = 1'b0;
						set_nxt[tgt].dirty = 1'b0;
						do_tag_we          = hit_any;
						do_wb = hit_any && set_rd[tgt].dirty;
					end else if (!hit_any) begin
						tgt                = victim;
						set_nxt[tgt].valid = 1'b1;
						set_nxt[tgt].dirty = 1'b0;
						set_nxt[tgt].tag   = ea_tag;
						lru_nxt   = lru_touch(lru_rd, victim);
						do_fill   = 1'b1;
						do_tag_we = 1'b1;
						do_lru_we = 1'b1;
					end
				end
				// reserved codes leave the arrays alone
				default: begin
				end
			endcase
		end
	end

	// sequencer
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r <= ST_IDLE;
		end else if (i_ce) begin
			unique case (state_r)
				ST_IDLE: begin
					if (accept) begin
						state_r <= ST_EVAL;
					end
				end
				ST_EVAL: begin
					if (do_wb) begin
						state_r <= ST_WB;
					end else if (do_fill) begin
						state_r <= ST_FILL;
					end else if (do_tag_we || do_lru_we) begin
						state_r <= ST_WRITE;
					end else begin
						state_r <= ST_IDLE;
					end
				end
				ST_WB: begin
					if (i_wb_ack) begin
						state_r <= ST_WRITE;
					end
				end
				ST_FILL: begin
					if (i_fill_ack) begin
						state_r <= ST_WRITE;
					end
				end
				ST_WRITE: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// instruction capture
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ea_r <= '0;
			op_r <= '0;
		end else if (accept) begin
			ea_r <= ea_nxt;
			op_r <= i_req.op;
		end
	end

	// array update held until any memory traffic is over
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tag_we_r <= 1'b0;
			lru_we_r <= 1'b0;
			set_wr_r <= '0;
			lru_wr_r <= '0;
		end else if (i_ce && state_r == ST_EVAL) begin
			tag_we_r <= do_tag_we;
			lru_we_r <= do_lru_we;
			set_wr_r <= set_nxt;
			lru_wr_r <= lru_nxt;
		end
	end

	// completion pulse and hit flag
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_done <= 1'b0;
			o_hit  <= 1'b0;
		end else if (i_ce) begin
			o_done <= (state_r == ST_WRITE) ||
				(state_r == ST_EVAL && !do_wb && !do_fill && !do_tag_we && !do_lru_we);
			if (state_r == ST_EVAL) begin
				o_hit <= hit_any;
			end
		end
	end

	// write back and refill requests stand until acknowledged
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_wb_req    <= 1'b0;
			o_wb_addr   <= '0;
			o_fill_req  <= 1'b0;
			o_fill_addr <= '0;
		end else if (i_ce) begin
			if (state_r == ST_EVAL && do_wb) begin
				o_wb_req  <= 1'b1;
				o_wb_addr <= {set_rd[tgt].tag, ea_set, {CMO_OFF_W{1'b0}}};
			end else if (state_r == ST_WB && i_wb_ack) begin
				o_wb_req <= 1'b0;
			end
			if (state_r == ST_EVAL && do_fill) begin
				o_fill_req  <= 1'b1;
				o_fill_addr <= {ea_tag, ea_set, {CMO_OFF_W{1'b0}}};
			end else if (state_r == ST_FILL && i_fill_ack) begin
				o_fill_req <= 1'b0;
			end
		end
	end

	// tag-low register; the hardware load wins over a software write
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_tag_low <= CMO_TL_RESET;
		end else if (i_ce) begin
			if (state_r == ST_EVAL && do_load) begin
				o_tag_low <= '0;
				// copy tag or lru into tag-low
				if (i_way_select_test_enable) begin
					o_tag_low[CMO_TL_LRU_LSB +: CMO_LRU_W] <= lru_rd;
				end else begin
					o_tag_low[31:CMO_TL_TAG_LSB]   <= set_rd[tgt].tag;
					o_tag_low[CMO_TL_VALID_BIT]    <= set_rd[tgt].valid;
					o_tag_low[CMO_TL_DIRTY_BIT]    <= set_rd[tgt].dirty;
				end
			end else if (i_tag_low_we) begin
				o_tag_low <= i_tag_low_wdata;
			end
		end
	end

	// tag array, one word per set holding all ways
	cmo_ram #(
		.WIDTH ($bits(cmo_set_t)),
		.DEPTH (2 ** CMO_IDX_W)
	) u_tag_ram (
		.i_ref_clk (i_ref_clk),
		.i_resetn  (i_resetn),
		.i_ce      (i_ce),
		.i_we      (state_r == ST_WRITE && tag_we_r),
		.i_addr    (ram_addr),
		.i_wdata   (set_wr_r),
		.o_rdata   (set_rd)
	);

	// way-select array
	cmo_ram #(
		.WIDTH (CMO_LRU_W),
		.DEPTH (2 ** CMO_IDX_W)
	) u_lru_ram (
		.i_ref_clk (i_ref_clk),
		.i_resetn  (i_resetn),
		.i_ce      (i_ce),
		.i_we      (state_r == ST_WRITE && lru_we_r),
		.i_addr    (ram_addr),
		.i_wdata   (lru_wr_r),
		.o_rdata   (lru_rd)
	);

endmodule

/* File: design/cmo_pkg.sv */
package cmo_pkg;

	// cache geometry
	localparam int CMO_WAYS  = 4;
	localparam int CMO_WAY_W = 2;
	localparam int CMO_SET_W = 6;
	localparam int CMO_OFF_W = 4;
	localparam int CMO_TAG_W = 32 - CMO_SET_W - CMO_OFF_W;
	localparam int CMO_IDX_W = CMO_SET_W + 1;
	localparam int CMO_LRU_W = 6;

	// index-type effective address fields
	localparam int CMO_EA_SET_LSB = CMO_OFF_W;
	localparam int CMO_EA_WAY_LSB = CMO_OFF_W + CMO_SET_W;
	localparam int CMO_EA_TAG_LSB = CMO_OFF_W + CMO_SET_W;

	// operation field split
	localparam int CMO_OP_SEL_LSB = 0;
	localparam int CMO_OP_CMD_LSB = 2;

	// cache select codes
	localparam logic [1:0] CMO_SEL_ICACHE = 2'h0;
	localparam logic [1:0] CMO_SEL_DCACHE = 2'h1;

	// operation codes
	localparam logic [2:0] CMO_CMD_IDX_INV   = 3'h0;
	localparam logic [2:0] CMO_CMD_LOAD_TAG  = 3'h1;
	localparam logic [2:0] CMO_CMD_STORE_TAG = 3'h2;
	localparam logic [2:0] CMO_CMD_HIT_INV   = 3'h4;
	localparam logic [2:0] CMO_CMD_FILL      = 3'h5;

	// tag-low register layout
	localparam int CMO_TL_TAG_LSB   = 32 - CMO_TAG_W;
	localparam int CMO_TL_VALID_BIT = 7;
	localparam int CMO_TL_DIRTY_BIT = 6;
	localparam int CMO_TL_LRU_LSB   = 0;
	localparam logic [31:0] CMO_TL_RESET = 32'h0000_0000;

	// lru pair bits: set means the higher way is the older of the pair
	localparam int CMO_LRU_P23 = 0;
	localparam int CMO_LRU_P12 = 1;
	localparam int CMO_LRU_P01 = 2;
	localparam int CMO_LRU_P03 = 3;
	localparam int CMO_LRU_P13 = 4;
	localparam int CMO_LRU_P02 = 5;

	// maintenance instruction as issued
	typedef struct packed {
		logic [4:0]  op;
		logic [4:0]  base_sel;
		logic [15:0] offset;
	} cmo_req_s;

	// one way of a set
	typedef struct packed {
		logic                 valid;
		logic                 dirty;
		logic [CMO_TAG_W-1:0] tag;
	} cmo_line_s;

	typedef cmo_line_s [CMO_WAYS-1:0] cmo_set_t;

endpackage

/* File: design/cmo_ram.sv */
`timescale 1ns/1ps

module cmo_ram #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW    = $clog2(DEPTH)
) (
	// clock and reset
	input  wire logic             i_ref_clk,
	input  wire logic             i_resetn,
	input  wire logic             i_ce,
	// access port
	input  wire logic             i_we,
	input  wire logic [AW-1:0]    i_addr,
	input  wire logic [WIDTH-1:0] i_wdata,
	output logic      [WIDTH-1:0] o_rdata
);

	logic [WIDTH-1:0] mem_r [DEPTH];

	// contents have no reset; software initialises the arrays
	always_ff @(posedge i_ref_clk) begin
		if (i_ce && i_we) begin
			mem_r[i_addr] <= i_wdata;
		end
	end

	// registered read, old data on a same-cycle write
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= '0;
		end else if (i_ce) begin
			o_rdata <= mem_r[i_addr];
		end
	end

endmodule

/* File: test/cmo_mem_model.sv */
`timescale 1ns/1ps

module cmo_mem_model (
	// clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_resetn,
	// answer delay in cycles, zero answers at once
	input  wire logic [3:0] i_delay,
	// write back and refill handshakes
	input  wire logic       i_wb_req,
	input  wire logic       i_fill_req,
	output logic            o_wb_ack,
	output logic            o_fill_ack
);
	logic [3:0] wb_cnt_r;
	logic [3:0] fill_cnt_r;

	// one ack pulse per request; counter clears while the ack is out so no second pulse
	always @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wb_cnt_r <= 4'h0;
			fill_cnt_r <= 4'h0;
			o_wb_ack <= 1'b0;
			o_fill_ack <= 1'b0;
		end else begin
			o_wb_ack <= i_wb_req && !o_wb_ack && wb_cnt_r == i_delay;
			o_fill_ack <= i_fill_req && !o_fill_ack && fill_cnt_r == i_delay;
			wb_cnt_r <= (!i_wb_req || o_wb_ack || wb_cnt_r == i_delay) ? 4'h0 : wb_cnt_r + 4'h1;
			fill_cnt_r <= (!i_fill_req || o_fill_ack || fill_cnt_r == i_delay) ? 4'h0
				: fill_cnt_r + 4'h1;
		end
	end
endmodule

/* File: test/cmo_engine_props.sv */
`timescale 1ns/1ps

module cmo_engine_props
	import cmo_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_resetn,
	// watched ports
	input  wire logic        i_ce,
	input  wire logic        i_req_valid,
	input  wire cmo_req_s    i_req,
	input  wire logic        o_req_ready,
	input  wire logic [4:0]  o_base_sel,
	input  wire logic        o_done,
	input  wire logic        i_tag_low_we,
	input  wire logic [31:0] i_tag_low_wdata,
	input  wire logic [31:0] o_tag_low,
	input  wire logic        o_wb_req,
	input  wire logic [31:0] o_wb_addr,
	input  wire logic        i_wb_ack,
	input  wire logic        o_fill_req,
	input  wire logic [31:0] o_fill_addr,
	input  wire logic        i_fill_ack
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);

	base_sel_a: assert property (o_base_sel == i_req.base_sel)
		else $error("base selector not passed on");
	take_busy_a: assert property (i_ce && i_req_valid && o_req_ready |=> !o_req_ready && !o_done)
		else $error("ready or done high right after a take");
	done_pulse_a: assert property (o_done |-> o_req_ready && !$past(o_req_ready) ##1 !o_done)
		else $error("done not a single pulse after busy");
	wb_hold_a: assert property (o_wb_req && !(i_wb_ack && i_ce) |=> o_wb_req && $stable(o_wb_addr))
		else $error("write back request dropped or moved before ack");
	wb_finish_a: assert property (o_wb_req && i_wb_ack && i_ce |=> !o_wb_req ##1 o_done)
		else $error("write back ack not followed by finish");
	fill_finish_a: assert property (o_fill_req && i_fill_ack && i_ce |=> !o_fill_req ##1 o_done)
		else $error("refill ack not followed by finish");
	line_addr_a: assert property ((!o_wb_req || o_wb_addr[3:0] == 4'h0)
		&& (!o_fill_req || o_fill_addr[3:0] == 4'h0))
		else $error("memory request address not line aligned");
	mem_busy_a: assert property (o_wb_req || o_fill_req |-> !o_req_ready && !(o_wb_req && o_fill_req))
		else $error("memory request while idle or both at once");
	tag_write_a: assert property (i_ce && i_tag_low_we && o_req_ready
		|=> o_tag_low == $past(i_tag_low_wdata))
		else $error("tag-low write lost");
endmodule

bind cmo_engine cmo_engine_props u_props (.i_ref_clk, .i_resetn, .i_ce, .i_req_valid, .i_req,
	.o_req_ready, .o_base_sel, .o_done, .i_tag_low_we, .i_tag_low_wdata, .o_tag_low, .o_wb_req,
	.o_wb_addr, .i_wb_ack, .o_fill_req, .o_fill_addr, .i_fill_ack);

/* File: test/cmo_engine_test.sv */
`timescale 1ns/1ps

module cmo_engine_test
	import cmo_pkg::*;
;
	localparam logic [21:0] TG = 22'h2A5C3;
	localparam logic [5:0]  ST = 6'h15;
	localparam logic [31:0] LA = {TG, ST, 4'h0};
	// tag in the top bits, then valid and dirty at bits 7 and 6
	localparam logic [31:0] DL = {TG, 10'h0C0};
	logic        i_ref_clk, i_resetn, i_req_valid, i_tag_low_we, i_way_select_test_enable, ce;
	logic        o_req_ready, o_done, o_hit, o_wb_req, o_fill_req, wb_ack, fill_ack;
	logic        wb_seen, fill_seen;
	logic [3:0]  dly;
	logic [4:0]  o_base_sel;
	logic [31:0] i_base_data, i_tag_low_wdata, o_tag_low, o_wb_addr, o_fill_addr, wb_a, fill_a;
	logic [4:0]  rs [5];
	cmo_req_s    i_req;
	int          mismatches, check_count, cyc;

	// design and memory side
	cmo_engine DUT (.i_ref_clk, .i_resetn, .i_ce(ce), .i_req_valid, .i_req, .o_req_ready,
		.o_base_sel, .i_base_data, .o_done, .o_hit, .i_tag_low_we, .i_tag_low_wdata, .o_tag_low,
		.i_way_select_test_enable, .o_wb_req, .o_wb_addr, .i_wb_ack(wb_ack), .o_fill_req,
		.o_fill_addr, .i_fill_ack(fill_ack));
	cmo_mem_model u_mem (.i_ref_clk, .i_resetn, .i_delay(dly), .i_wb_req(o_wb_req),
		.i_fill_req(o_fill_req), .o_wb_ack(wb_ack), .o_fill_ack(fill_ack));

	initial begin
		i_ref_clk = 1'b0;
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end

	// remember memory traffic of the current operation; cycle ceiling cuts hangs
	always @(posedge i_ref_clk) begin
		if (o_wb_req) begin wb_seen <= 1'b1; wb_a <= o_wb_addr; end
		if (o_fill_req) begin fill_seen <= 1'b1; fill_a <= o_fill_addr; end
		cyc++;
		if (cyc == 12000) begin mismatches++; print_verdict(); end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [31:0] ix(input logic [1:0] w, input logic [5:0] s);
		return {20'h0, w, s, 4'h0};
	endfunction

	// one instruction, base plus offset, waits for done under a bound
	task automatic op(input logic [2:0] c, input logic [1:0] s, input logic [31:0] b,
		input logic [15:0] f);
		int n;
		@(posedge i_ref_clk) #1;
		i_req_valid = 1'b1;
		i_req = {c, s, 5'h13, f};
		i_base_data = b;
		wb_seen = 1'b0;
		fill_seen = 1'b0;
		@(posedge i_ref_clk) #1;
		// selector looked at once the combinational copy has settled
		chk("base_sel", 32'h13, {27'h0, o_base_sel});
		i_req_valid = 1'b0;
		chk("ready", 32'h0, {31'h0, o_req_ready});
		n = 0;
		while (o_done !== 1'b1 && n < 60) begin @(posedge i_ref_clk) #1; n++; end
		chk("done", 32'h1, {31'h0, o_done});
	endtask

	task automatic tl(input logic [31:0] v);
		@(posedge i_ref_clk) #1;
		i_tag_low_we = 1'b1;
		i_tag_low_wdata = v;
		@(posedge i_ref_clk) #1;
		i_tag_low_we = 1'b0;
	endtask

	task automatic ld(input logic [1:0] s, input logic [1:0] w);
		op(CMO_CMD_LOAD_TAG, s, ix(w, ST), 16'h0);
	endtask

	// both caches, tag and lru arrays written alternately entry by entry, cleared by store tag
	task automatic t_init();
		tl(32'h0);
		for (int k = 0; k < 1024; k++) begin
			i_way_select_test_enable = k[0];
			op(CMO_CMD_STORE_TAG, {1'b0, k[1]}, ix(k[3:2], k[9:4]), 16'h0);
		end
		i_way_select_test_enable = 1'b0;
	endtask

	task automatic t_tag();
		tl(DL);
		op(CMO_CMD_STORE_TAG, CMO_SEL_DCACHE, ix(2'h1, ST) + 32'h4, 16'hFFFC);
		ld(CMO_SEL_DCACHE, 2'h1);
		chk("dtag", DL, {o_tag_low[31:6], 6'h0});
		ld(CMO_SEL_ICACHE, 2'h1);
		chk("itag", 32'h0, {o_tag_low[31:6], 6'h0});
	endtask

	task automatic t_lru();
		logic [5:0] v [3] = '{6'h00, 6'h2C, 6'h3F};
		i_way_select_test_enable = 1'b1;
		for (int i = 0; i < 3; i++) begin
			tl({26'h0, v[i]});
			op(CMO_CMD_STORE_TAG, CMO_SEL_DCACHE, ix(2'h0, ST), 16'h0);
			tl(32'h0);
			ld(CMO_SEL_DCACHE, 2'h0);
			chk("lru", {26'h0, v[i]}, {26'h0, o_tag_low[5:0]});
		end
		i_way_select_test_enable = 1'b0;
	endtask

	// dirty line dropped by hit invalidate, written back by the other two
	task automatic t_dinv(input logic [2:0] c, input logic [31:0] b, input logic wb);
		tl(DL);
		op(CMO_CMD_STORE_TAG, CMO_SEL_DCACHE, ix(2'h1, ST), 16'h0);
		op(c, CMO_SEL_DCACHE, b, 16'hFFF0);
		if (c != CMO_CMD_IDX_INV) chk("hit", 32'h1, {31'h0, o_hit});
		chk("wb_seen", {31'h0, wb}, {31'h0, wb_seen});
		if (wb) chk("wb_addr", LA, wb_a);
		ld(CMO_SEL_DCACHE, 2'h1);
		chk("dvalid", 32'h0, {31'h0, o_tag_low[CMO_TL_VALID_BIT]});
	endtask

	task automatic t_ifill();
		op(CMO_CMD_FILL, CMO_SEL_ICACHE, LA + 32'h4, 16'h0);
		chk("ihit", 32'h0, {31'h0, o_hit});
		chk("fill_addr", {LA[31:1], ~fill_seen}, fill_a);
		ld(CMO_SEL_ICACHE, 2'h0);
		chk("ifill", {TG, 1'b1}, {9'h0, o_tag_low[31:10], o_tag_low[7]});
		// refilled way 0 becomes most recent: order 1230
		i_way_select_test_enable = 1'b1;
		ld(CMO_SEL_ICACHE, 2'h0);
		chk("ilru", 32'h2C, {26'h0, o_tag_low[5:0]});
		i_way_select_test_enable = 1'b0;
		op(CMO_CMD_IDX_INV, CMO_SEL_ICACHE, ix(2'h0, ST), 16'h0);
		ld(CMO_SEL_ICACHE, 2'h0);
		chk("ivalid", 32'h0, {31'h0, o_tag_low[CMO_TL_VALID_BIT]});
	endtask

	task automatic t_rsvd();
		tl(DL);
		op(CMO_CMD_STORE_TAG, CMO_SEL_DCACHE, ix(2'h2, ST), 16'h0);
		for (int i = 0; i < 5; i++) begin
			op(rs[i][4:2], rs[i][1:0], ix(2'h2, ST), 16'h0);
			chk("rsvd_wb", 32'h0, {31'h0, wb_seen});
		end
		ld(CMO_SEL_DCACHE, 2'h2);
		chk("rsvd_tag", DL, {o_tag_low[31:6], 6'h0});
	endtask

	// enable low: a request and a tag-low write must both be ignored
	task automatic t_ce();
		logic [31:0] keep;
		keep = o_tag_low;
		@(posedge i_ref_clk) #1;
		ce = 1'b0;
		i_req_valid = 1'b1;
		tl(32'h1234_5678);
		chk("ce_ready", 32'h1, {31'h0, o_req_ready});
		chk("ce_hold", keep, o_tag_low);
		i_req_valid = 1'b0;
		@(posedge i_ref_clk) #1;
		ce = 1'b1;
	endtask

	initial begin
		rs = '{5'h0D, 5'h19, 5'h1D, 5'h02, 5'h03};
		{i_resetn, i_req_valid, i_tag_low_we, i_way_select_test_enable} = 4'h0;
		ce = 1'b1;
		i_req = '0;
		{i_base_data, i_tag_low_wdata} = 64'h0;
		{mismatches, check_count, cyc} = 0;
		dly = 4'h0;
		repeat (20) @(posedge i_ref_clk);
		#1 i_resetn = 1'b1;
		chk("tag_low_rst", CMO_TL_RESET, o_tag_low);
		t_init();
		t_tag();
		t_lru();
		t_dinv(CMO_CMD_HIT_INV, LA + 32'h18, 1'b0);
		dly = 4'h5;
		t_dinv(CMO_CMD_IDX_INV, ix(2'h1, ST) + 32'h10, 1'b1);
		t_dinv(CMO_CMD_FILL, LA + 32'h10, 1'b1);
		t_ifill();
		t_rsvd();
		t_ce();
		print_verdict();
	end
endmodule
